// File: hw/dpc_consts.svh
/*
  Constants of the serial potentiometer command decoder: frame layout,
  opcodes, bit counts and timing.
  Assumes a 25 MHz system clock and a serial clock well below a quarter of it.
*/
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// Identification byte fields.
`define DPC_TYPE_HI 7
`define DPC_TYPE_LO 4
`define DPC_ID_ZERO 3
`define DPC_ADDR_HI 2
`define DPC_ADDR_LO 1
`define DPC_RW_BIT 0
// Arbitrary device type code.
`define DPC_DEVICE_TYPE 4'h3

// Instruction byte fields and codes.
`define DPC_NIB_HI 7
`define DPC_NIB_LO 4
`define DPC_PTR_HI 3
`define DPC_PTR_LO 2
`define DPC_LOW_HI 1
`define DPC_LOW_LO 0
`define DPC_OP_RD_WIPER 8'h80
`define DPC_OP_WR_WIPER 8'hA0
`define DPC_OP_STATUS 8'h41
`define DPC_NIB_SLOT_RD 4'hA
`define DPC_NIB_SLOT_WR 4'hC
`define DPC_NIB_TO_WIPER 4'hC
`define DPC_NIB_TO_SLOT 4'hE
`define DPC_LOW_ZERO 2'h0

// Frame bit counts.
`define DPC_BITS_ID 6'h08
`define DPC_BITS_INSTR 6'h10
`define DPC_BITS_HI 6'h18
`define DPC_BITS_FULL 6'h20

// Timing.
`define DPC_CLK_MHZ 25
`define DPC_NV_WRITE_US 10000
`define DPC_WIPER_DELAY_NS 1000
`define DPC_NV_WRITE_CYC (`DPC_NV_WRITE_US * `DPC_CLK_MHZ)
`define DPC_WIPER_DELAY_CYC ((`DPC_WIPER_DELAY_NS * `DPC_CLK_MHZ + 999) / 1000)

`endif

// File: hw/dpc_pkg.sv
/*
  Types of the serial potentiometer command decoder.
  Assumes the constants header is compiled alongside.
*/
package dpc_pkg;

  typedef enum logic [2:0]
  {
    DPC_PH_IDLE = 3'h0,
    DPC_PH_ID = 3'h1,
    DPC_PH_INSTR = 3'h3,
    DPC_PH_DATA = 3'h2,
    DPC_PH_IGNORE = 3'h6
  } dpc_phase_type;

  typedef enum logic [2:0]
  {
    DPC_CMD_NONE = 3'h0,
    DPC_CMD_RD_WIPER = 3'h1,
    DPC_CMD_WR_WIPER = 3'h2,
    DPC_CMD_RD_SLOT = 3'h3,
    DPC_CMD_WR_SLOT = 3'h4,
    DPC_CMD_TO_WIPER = 3'h5,
    DPC_CMD_TO_SLOT = 3'h6,
    DPC_CMD_RD_STATUS = 3'h7
  } dpc_cmd_type;

  typedef struct packed
  {
    logic en;
    logic [1:0] addr;
    logic [9:0] data;
  } dpc_slot_write_type;

endpackage

// File: hw/dpc_slot_store.sv
/*
  Four stored wiper slots with one write port and a registered read port.
  Assumes the owner holds the read address steady for two clocks before use.
*/
module dpc_slot_store
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
)
(
  // Clock.
  input wire logic sys_clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port.
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      cells[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rd_data <= cells[rd_addr];
  end

endmodule

// File: hw/dpc_decoder.sv
/*
  Serial command decoder of a single digital potentiometer: frames the
  serial stream, decodes seven instructions, keeps the wiper register and
  the nonvolatile write timer, and drives the wiper tap output.
  Assumes the serial pins come from outside this clock domain and that the
  serial clock half period spans at least four system clocks.
*/
`include "dpc_consts.svh"

module dpc_decoder
#(
  parameter int NV_WRITE_CYCLES = `DPC_NV_WRITE_CYC,
  parameter int WIPER_DELAY_CYCLES = `DPC_WIPER_DELAY_CYC,
  parameter logic [3:0] DEVICE_TYPE = `DPC_DEVICE_TYPE
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link pins.
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  // Strap and protect pins.
  input wire logic [1:0] slave_addr_pin,
  input wire logic write_protect_n_pin,
  // Potentiometer side.
  output logic [9:0] wiper_latch,
  output logic write_busy
);

  import dpc_pkg::*;

  localparam int NV_W = $clog2(NV_WRITE_CYCLES + 1);
  localparam int WD_W = $clog2(WIPER_DELAY_CYCLES + 1);

  logic [2:0] cs_meta;
  logic [2:0] cs_sync;
  logic cs_prev;
  logic sck_prev;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic [1:0] addr_sync;
  logic wp_n_sync;
  dpc_phase_type phase;
  dpc_phase_type next_phase;
  dpc_cmd_type cmd;
  dpc_cmd_type next_cmd;
  logic rw;
  logic [5:0] bit_count;
  logic [5:0] next_count;
  logic [7:0] in_shift;
  logic [7:0] next_shift;
  logic [1:0] data_hi;
  logic [9:0] rx_data;
  logic [1:0] slot_ptr;
  logic frame_complete;
  logic [1:0] load_pend;
  logic [15:0] out_shift;
  logic [9:0] wiper_position_reg;
  logic wiper_load;
  logic [WD_W-1:0] tap_count;
  logic [NV_W-1:0] nv_count;
  logic write_status_reg;
  logic recall_pend;
  logic recall_wait;
  logic exec;
  logic nv_allowed;
  dpc_slot_write_type slot_wr;
  logic [1:0] rd_addr;
  logic [9:0] rd_data;

  // Two-stage synchronisers; bit order is chip select, clock, data.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_meta <= 3'h0;
      cs_sync <= 3'h0;
    end
    else
    begin
      cs_meta <= {cs_n_pin, sck_pin, si_pin};
      cs_sync <= cs_meta;
    end
  end

  // Edge history; select history starts low so no frame begins until a real fall.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_prev <= 1'b0;
      sck_prev <= 1'b0;
    end
    else
    begin
      cs_prev <= cs_sync[2];
      sck_prev <= cs_sync[1];
    end
  end

  assign cs_fall = ~cs_sync[2] & cs_prev;
  assign cs_rise = cs_sync[2] & ~cs_prev;
  assign sck_rise = cs_sync[1] & ~sck_prev;
  assign sck_fall = ~cs_sync[1] & sck_prev;

  // Address straps and write protect are slow levels from pins.
  logic [2:0] strap_meta;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_meta <= 3'h0;
      addr_sync <= 2'h0;
      wp_n_sync <= 1'b0;
    end
    else
    begin
      strap_meta <= {slave_addr_pin, write_protect_n_pin};
      addr_sync <= strap_meta[2:1];
      wp_n_sync <= strap_meta[0];
    end
  end

  assign next_shift = {in_shift[6:0], cs_sync[0]};
  assign next_count = (bit_count == `DPC_BITS_FULL) ? bit_count : bit_count + 6'h01;

  // Instruction decode from the direction bit and instruction byte.
  always_comb
  begin
    next_cmd = DPC_CMD_NONE;
    if (next_shift == `DPC_OP_RD_WIPER && rw)
    begin
      next_cmd = DPC_CMD_RD_WIPER;
    end
    else if (next_shift == `DPC_OP_WR_WIPER && !rw)
    begin
      next_cmd = DPC_CMD_WR_WIPER;
    end
    else if (next_shift == `DPC_OP_STATUS && rw)
    begin
      next_cmd = DPC_CMD_RD_STATUS;
    end
    else if (next_shift[`DPC_LOW_HI:`DPC_LOW_LO] == `DPC_LOW_ZERO)
    begin
      case (next_shift[`DPC_NIB_HI:`DPC_NIB_LO])
        `DPC_NIB_SLOT_RD:
          next_cmd = rw ? DPC_CMD_RD_SLOT : DPC_CMD_NONE;
        `DPC_NIB_SLOT_WR:
          next_cmd = rw ? DPC_CMD_TO_WIPER : DPC_CMD_WR_SLOT;
        `DPC_NIB_TO_SLOT:
          next_cmd = rw ? DPC_CMD_NONE : DPC_CMD_TO_SLOT;
        default:
          next_cmd = DPC_CMD_NONE;
      endcase
    end
  end

  // Frame phase after the current rising serial clock.
  always_comb
  begin
    next_phase = phase;
    case (phase)
      DPC_PH_ID:
        if (next_count == `DPC_BITS_ID)
        begin
          if (next_shift[`DPC_TYPE_HI:`DPC_TYPE_LO] == DEVICE_TYPE
              && !next_shift[`DPC_ID_ZERO]
              && next_shift[`DPC_ADDR_HI:`DPC_ADDR_LO] == addr_sync)
          begin
            next_phase = DPC_PH_INSTR;
          end
          else
          begin
            next_phase = DPC_PH_IGNORE;
          end
        end
      DPC_PH_INSTR:
        if (next_count == `DPC_BITS_INSTR)
        begin
          next_phase = (next_cmd == DPC_CMD_NONE) ? DPC_PH_IGNORE : DPC_PH_DATA;
        end
      DPC_PH_DATA:
        next_phase = DPC_PH_DATA;
      DPC_PH_IGNORE:
        next_phase = DPC_PH_IGNORE;
      default:
        next_phase = DPC_PH_IDLE;
    endcase
  end

  // Framing: a select fall restarts, a high select ends the frame.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= DPC_PH_IDLE;
      bit_count <= 6'h00;
      in_shift <= 8'h00;
    end
    else if (cs_sync[2])
    begin
      phase <= DPC_PH_IDLE;
    end
    else if (cs_fall)
    begin
      phase <= DPC_PH_ID;
      bit_count <= 6'h00;
    end
    else if (sck_rise && phase != DPC_PH_IDLE && phase != DPC_PH_IGNORE)
    begin
      in_shift <= next_shift;
      bit_count <= next_count;
      phase <= next_phase;
    end
  end

  // Captured fields of the frame.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rw <= 1'b0;
      cmd <= DPC_CMD_NONE;
      slot_ptr <= 2'h0;
      data_hi <= 2'h0;
      rx_data <= 10'h000;
      frame_complete <= 1'b0;
    end
    else if (cs_fall)
    begin
      cmd <= DPC_CMD_NONE;
      frame_complete <= 1'b0;
    end
    else if (sck_rise && phase != DPC_PH_IDLE && phase != DPC_PH_IGNORE)
    begin
      if (phase == DPC_PH_ID && next_count == `DPC_BITS_ID)
      begin
        rw <= next_shift[`DPC_RW_BIT];
      end
      if (phase == DPC_PH_INSTR && next_count == `DPC_BITS_INSTR)
      begin
        cmd <= next_cmd;
        slot_ptr <= next_shift[`DPC_PTR_HI:`DPC_PTR_LO];
        frame_complete <= (next_cmd == DPC_CMD_TO_WIPER
                           || next_cmd == DPC_CMD_TO_SLOT);
      end
      if (phase == DPC_PH_DATA && next_count == `DPC_BITS_HI)
      begin
        data_hi <= next_shift[1:0];
      end
      if (phase == DPC_PH_DATA && bit_count == `DPC_BITS_FULL - 6'h01)
      begin
        rx_data <= {data_hi, next_shift};
        frame_complete <= 1'b1;
      end
    end
  end

  assign exec = cs_rise & frame_complete;
  assign nv_allowed = wp_n_sync & ~write_status_reg;

  // Power-up recall of slot zero: one clock for the read, one to load.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      recall_pend <= 1'b1;
      recall_wait <= 1'b1;
    end
    else
    begin
      recall_wait <= 1'b0;
      if (!recall_wait)
      begin
        recall_pend <= 1'b0;
      end
    end
  end

  assign rd_addr = recall_pend ? 2'h0 : slot_ptr;

  // Wiper register: recall, host write, or transfer from a slot.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wiper_position_reg <= 10'h000;
      wiper_load <= 1'b0;
    end
    else
    begin
      wiper_load <= 1'b0;
      if (recall_pend && !recall_wait)
      begin
        wiper_position_reg <= rd_data;
        wiper_load <= 1'b1;
      end
      else if (exec && cmd == DPC_CMD_WR_WIPER)
      begin
        wiper_position_reg <= rx_data;
        wiper_load <= 1'b1;
      end
      else if (exec && cmd == DPC_CMD_TO_WIPER)
      begin
        wiper_position_reg <= rd_data;
        wiper_load <= 1'b1;
      end
    end
  end

  // Tap output follows the wiper register after the response delay.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tap_count <= '0;
      wiper_latch <= 10'h000;
    end
    else if (wiper_load)
    begin
      tap_count <= WD_W'(WIPER_DELAY_CYCLES);
    end
    else if (tap_count != '0)
    begin
      tap_count <= tap_count - WD_W'(1);
      if (tap_count == WD_W'(1))
      begin
        wiper_latch <= wiper_position_reg;
      end
    end
  end

  // Slot writes start on the select rise that ends a complete write.
  always_comb
  begin
    slot_wr.en = 1'b0;
    slot_wr.addr = slot_ptr;
    slot_wr.data = rx_data;
    if (exec && nv_allowed && cmd == DPC_CMD_WR_SLOT)
    begin
      slot_wr.en = 1'b1;
    end
    else if (exec && nv_allowed && cmd == DPC_CMD_TO_SLOT)
    begin
      slot_wr.en = 1'b1;
      slot_wr.data = wiper_position_reg;
    end
  end

  // Write-in-progress timer covering the nonvolatile write time.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      nv_count <= '0;
      write_status_reg <= 1'b0;
    end
    else if (slot_wr.en)
    begin
      nv_count <= NV_W'(NV_WRITE_CYCLES);
      write_status_reg <= 1'b1;
    end
    else if (nv_count != '0)
    begin
      nv_count <= nv_count - NV_W'(1);
      if (nv_count == NV_W'(1))
      begin
        write_status_reg <= 1'b0;
      end
    end
  end

  assign write_busy = write_status_reg;

  dpc_slot_store
  #(
    .WIDTH(10),
    .DEPTH(4)
  )
  u_store
  (
    .sys_clk(sys_clk),
    .wr_en(slot_wr.en),
    .wr_addr(slot_wr.addr),
    .wr_data(slot_wr.data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Read data is loaded two clocks after the instruction byte ends.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      load_pend <= 2'h0;
    end
    else
    begin
      load_pend <= {load_pend[0],
                    sck_rise && phase == DPC_PH_INSTR && next_count == `DPC_BITS_INSTR};
    end
  end

  // Serial output: leading zero bits then the data word, changing on falling clock.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      out_shift <= 16'h0000;
      so_out <= 1'b0;
    end
    else if (load_pend[1])
    begin
      case (cmd)
        DPC_CMD_RD_WIPER:
          out_shift <= {6'h00, wiper_position_reg};
        DPC_CMD_RD_SLOT:
          out_shift <= {6'h00, rd_data};
        DPC_CMD_RD_STATUS:
          out_shift <= {15'h0000, write_status_reg};
        default:
          out_shift <= 16'h0000;
      endcase
    end
    else if (sck_fall && phase == DPC_PH_DATA)
    begin
      so_out <= out_shift[15];
      out_shift <= {out_shift[14:0], 1'b0};
    end
  end

  // Output driven only during the data part of a selected read.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      so_oe <= 1'b0;
    end
    else
    begin
      so_oe <= !cs_sync[2] && phase == DPC_PH_DATA
               && (cmd == DPC_CMD_RD_WIPER || cmd == DPC_CMD_RD_SLOT
                   || cmd == DPC_CMD_RD_STATUS);
    end
  end

endmodule

// File: tb/dpc_decoder_monitor.sv
/*
  Concurrent checks on the serial potentiometer decoder's ports.
  Assumes one sys_clk domain with active-high reset rst.
*/
module dpc_decoder_monitor
#(
  parameter int NV_WRITE_CYCLES = 250000,
  parameter int WIPER_DELAY_CYCLES = 25,
  parameter logic [3:0] DEVICE_TYPE = 4'h3
)
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Serial link.
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic so_out,
  input wire logic so_oe,
  // Straps.
  input wire logic [1:0] slave_addr_pin,
  input wire logic write_protect_n_pin,
  // Potentiometer side.
  input wire logic [9:0] wiper_latch,
  input wire logic write_busy
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  int busy_cnt;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      busy_cnt <= 0;
    else
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
  end

  chk_so_float: assert property (
    cs_n_pin [*5] |-> !so_oe) else $error("serial out driven while deselected");
  chk_busy_start: assert property (
    $rose(write_busy) |-> cs_n_pin && $past(cs_n_pin)) else $error("write began in frame");
  chk_busy_length: assert property (
    $fell(write_busy) |-> busy_cnt >= NV_WRITE_CYCLES && busy_cnt <= NV_WRITE_CYCLES + 1)
    else $error("nonvolatile write time wrong");
  chk_protect_blocks: assert property (
    $rose(write_busy) |-> write_protect_n_pin) else $error("write while protected");
  chk_oe_in_frame: assert property (
    $rose(so_oe) |-> !cs_n_pin) else $error("output enabled outside a frame");
  chk_oe_after_instr: assert property (
    $rose(so_oe) |-> $past(sck_pin)) else $error("output enabled off the instruction edge");
  chk_so_on_fall: assert property (
    so_oe && $past(so_oe) && $changed(so_out) |-> !sck_pin)
    else $error("serial out moved while clock high");
  chk_wiper_idle: assert property (
    $changed(wiper_latch) |-> cs_n_pin && $past(cs_n_pin, 3))
    else $error("wiper moved inside a frame");
endmodule

bind dpc_decoder dpc_decoder_monitor #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES),
  .WIPER_DELAY_CYCLES(WIPER_DELAY_CYCLES),
  .DEVICE_TYPE(DEVICE_TYPE)
) u_mon (.sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
  .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe), .slave_addr_pin(slave_addr_pin),
  .write_protect_n_pin(write_protect_n_pin), .wiper_latch(wiper_latch),
  .write_busy(write_busy));

// File: tb/dpc_host_model.sv
/*
  Host serial controller: frames commands MSB first in clock mode 0.
  Assumes sys_clk at 25 MHz; the serial clock period is eight system clocks.
*/
module dpc_host_model
(
  // Clock.
  input wire logic sys_clk,
  // Serial link.
  output logic cs_n_pin,
  output logic sck_pin,
  output logic si_pin,
  input wire logic so_out,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cs_n_pin = 1'b1;
    sck_pin = 1'b0;
    si_pin = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask

  // Sends the top nbits of word and gathers the line from bit 16 onward.
  task automatic xfer(input logic [31:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge sys_clk);
    cs_n_pin = 1'b0;
    half();
    for (int i = 0; i < nbits; i++)
    begin
      si_pin = word[31 - i];
      half();
      sck_pin = 1'b1;
      if (i >= 16)
        rd = {rd[14:0], so_oe & so_out};
      half();
      sck_pin = 1'b0;
    end
    half();
    cs_n_pin = 1'b1;
    si_pin = ~si_pin;
    repeat (16) @(negedge sys_clk);
  endtask
endmodule

// File: tb/dpc_decoder_test.sv
/*
  Self-checking bench of the serial potentiometer decoder.
  Assumes the host model and the bound monitor are compiled alongside.
*/
module dpc_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dpc_pkg::*;

  localparam int NV = 2000;
  localparam int WD = 4;
  // Arbitrary device type code.
  localparam logic [3:0] DT = 4'h3;

  logic sys_clk, rst, cs_n_pin, sck_pin, si_pin, so_out, so_oe, write_protect_n_pin;
  logic write_busy;
  logic [1:0] slave_addr_pin, addr_sel;
  logic [3:0] type_sel;
  logic [9:0] wiper_latch;
  logic [9:0] slots [4];
  logic [9:0] wval;
  logic [15:0] rd, got_v;
  logic [15:0] exp_q [$];
  integer seed;
  int n_mismatch = 0;
  int checks_done = 0;
  event got_ev;

  dpc_decoder #(.NV_WRITE_CYCLES(NV), .WIPER_DELAY_CYCLES(WD), .DEVICE_TYPE(DT)) dut (
    .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe), .slave_addr_pin(slave_addr_pin),
    .write_protect_n_pin(write_protect_n_pin), .wiper_latch(wiper_latch),
    .write_busy(write_busy));

  dpc_host_model host (.sys_clk(sys_clk), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .so_out(so_out), .so_oe(so_oe));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] id_byte(input logic rw);
    return {type_sel, 1'b0, addr_sel, rw};
  endfunction

  task automatic note(input logic [15:0] exp, input logic [15:0] got);
    exp_q.push_back(exp);
    got_v = got;
    -> got_ev;
    @(negedge sys_clk);
  endtask

  task automatic cmd4(input logic rw, input logic [7:0] op, input logic [9:0] d);
    host.xfer({id_byte(rw), op, 6'h00, d}, 32, rd);
  endtask

  task automatic cmd2(input logic rw, input logic [7:0] op);
    host.xfer({id_byte(rw), op, 16'h0000}, 16, rd);
  endtask

  task automatic wait_nv();
    int k;
    cmd4(1'b1, 8'h41, 10'h000);
    note(16'h0001, rd);
    note(16'h0001, {15'h0000, write_busy});
    for (k = 0; k < 20 && rd[0] !== 1'b0; k++)
      cmd4(1'b1, 8'h41, 10'h000);
    note(16'h0000, rd);
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(got_ev)
  begin
    checks_done++;
    if (exp_q[0] !== got_v)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp_q[0], got_v);
    end
    void'(exp_q.pop_front());
  end

  initial
  begin
    #3000000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    seed = 32'h29466d2e;
    rst = 1'b1;
    slave_addr_pin = 2'h2;
    addr_sel = 2'h2;
    type_sel = DT;
    write_protect_n_pin = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (int p = 0; p < 4; p++)
    begin
      slots[p] = 10'($random(seed));
      cmd4(1'b0, {4'hC, 2'(p), 2'h0}, slots[p]);
      wait_nv();
    end
    for (int p = 0; p < 4; p++)
    begin
      cmd4(1'b1, {4'hA, 2'(p), 2'h0}, 10'h000);
      note({6'h00, slots[p]}, rd);
    end
    wval = 10'($random(seed));
    cmd4(1'b0, 8'hA0, wval);
    note({6'h00, wval}, {6'h00, wiper_latch});
    cmd4(1'b1, 8'h80, 10'h000);
    note({6'h00, wval}, rd);
    cmd2(1'b1, 8'hC8);
    note({6'h00, slots[2]}, {6'h00, wiper_latch});
    cmd2(1'b0, 8'hE4);
    wait_nv();
    slots[1] = slots[2];
    cmd4(1'b1, 8'hA4, 10'h000);
    note({6'h00, slots[1]}, rd);
    write_protect_n_pin = 1'b0;
    cmd4(1'b0, 8'hCC, ~slots[3]);
    cmd4(1'b1, 8'h41, 10'h000);
    note(16'h0000, rd);
    write_protect_n_pin = 1'b1;
    cmd4(1'b1, 8'hAC, 10'h000);
    note({6'h00, slots[3]}, rd);
    // Each pass spoils a wiper write in one way; the wiper must hold.
    for (int c = 0; c < 4; c++)
    begin
      addr_sel = (c == 0) ? 2'h1 : 2'h2;
      type_sel = (c == 1) ? ~DT : DT;
      host.xfer({id_byte(1'b0), (c == 3) ? 8'hA4 : 8'hA0, 6'h00, ~slots[2]},
        (c == 2) ? 24 : 32, rd);
      note({6'h00, slots[2]}, {6'h00, wiper_latch});
    end
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (20) @(negedge sys_clk);
    note({6'h00, slots[0]}, {6'h00, wiper_latch});
    note(16'h0000, {15'h0000, so_oe});
    print_verdict();
  end
endmodule
